// ==== logic/fmv_dflash.sv ====
// fmv_dflash: data array of 16-bit words, synchronous read, one write port.
// assumes: single clock; words never written since reset read as erased.
`timescale 1ns/1ps
module fmv_dflash #(
    parameter int WORDS = 512,
    parameter int AW = $clog2(WORDS)
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    // read port, data one cycle after rd_en
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [15:0] rd_data
);
    import fmv_pkg::*;

    typedef struct packed {
        logic [WORDS-1:0] used;
        logic [15:0] rdata;
    } fmv_arr_t;

    fmv_arr_t s_q;
    fmv_arr_t s_d;
    logic [15:0] mem [WORDS];

    assign rd_data = s_q.rdata;

    // =========================================================
    // next state: written map and read register
    always_comb
    begin
        s_d = s_q;
        if (wr_en)
        begin
            s_d.used[wr_addr] = 1'b1;
        end
        if (rd_en)
        begin
            s_d.rdata = s_q.used[rd_addr] ? mem[rd_addr] : FMV_ERASED;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // word storage, no reset
    always_ff @(posedge pclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule : fmv_dflash

// ==== logic/fmv_pkg.sv ====
// fmv_pkg: register map, command codes, index values and margin codes
// for the flash margin / erase-verify / program command sequencer.
// assumes: a 32-bit APB register bus and a 16-bit word data array.
package fmv_pkg;

    // =========================================================
    // register offsets (byte addresses on APB)
    localparam logic [7:0] FMV_ADDR_STAT = 8'h00;
    localparam logic [7:0] FMV_ADDR_CFG = 8'h04;
    localparam logic [7:0] FMV_ADDR_IDX = 8'h08;
    localparam logic [7:0] FMV_ADDR_CCOB = 8'h0C;
    localparam logic [7:0] FMV_ADDR_DPROT = 8'h10;
    localparam logic [7:0] FMV_ADDR_MARGIN = 8'h14;

    // =========================================================
    // field positions
    localparam int FMV_STAT_COMMAND_COMPLETE_FLAG = 7;
    localparam int FMV_STAT_ACCESS_ERROR_FLAG = 5;
    localparam int FMV_STAT_PROTECTION_VIOLATION_FLAG = 4;
    localparam int FMV_STAT_VERR = 1;
    localparam int FMV_STAT_UERR = 0;
    localparam int FMV_CFG_COMMAND_COMPLETE_IRQ_ENABLE = 7;
    localparam int FMV_DPROT_EN = 15;
    localparam int FMV_MARGIN_PF_LSB = 4;

    // =========================================================
    // commands and parameter word indices
    localparam logic [7:0] FMV_CMD_FIELD_MARGIN = 8'h0E;
    localparam logic [7:0] FMV_CMD_ERASE_VERIFY = 8'h10;
    localparam logic [7:0] FMV_CMD_PROGRAM = 8'h11;
    localparam logic [2:0] FMV_IDX_CMD = 3'h0;
    localparam logic [2:0] FMV_IDX_ADDR = 3'h1;
    localparam logic [2:0] FMV_IDX_COUNT = 3'h2;
    localparam logic [2:0] FMV_IDX_WORD0 = 3'h2;
    localparam logic [2:0] FMV_IDX_WORD3 = 3'h5;
    localparam int FMV_NUM_CCOB = 6;

    // =========================================================
    // margin codes, block codes, array layout
    localparam logic [15:0] FMV_MARGIN_NORMAL = 16'h0000;
    localparam logic [15:0] FMV_MARGIN_MAX = 16'h0004;
    localparam logic [1:0] FMV_BLK_DFLASH = 2'h0;
    localparam logic [1:0] FMV_BLK_PFLASH = 2'h3;
    localparam logic [15:0] FMV_DF_START = 16'h0400;
    localparam logic [15:0] FMV_ERASED = 16'hFFFF;

    // sequencer states
    typedef enum logic [2:0] {
        FMV_ST_IDLE,
        FMV_ST_CHECK,
        FMV_ST_EV_RD,
        FMV_ST_EV_CMP,
        FMV_ST_PG_WR,
        FMV_ST_PG_RD,
        FMV_ST_PG_CMP
    } fmv_state_t;

endpackage : fmv_pkg

// ==== logic/fmv_seq.sv ====
// fmv_seq: command sequencer for set-field-margin, data array erase-verify
// and data array program, with APB register access.
// assumes: APB master, special_mode and array_ecc_fatal synchronous inputs.
// Function
// - margin command 0x0E accepted only in special modes
// - valid margin command applies level, then sets complete flag
// - data target affects data reads; program target affects both arrays
// - margin codes 0 to 4 valid, anything else invalid
// - margin command errors set access error only, never others
// - erase-verify checks every word erased, then sets complete flag
// - erase-verify access error on index, mode, address, odd, overrun (code has no mode check)
// - erase-verify sets verify and uncorrectable flags, never protection
// - program command 0x11 writes one to four words from indices 2-5
// - word count comes from the index at launch
// - protected target area sets protection flag, nothing programmed
// - program access error on index, mode, address, odd, overrun (code has no mode check)
// - program verifies written words, flags verify and uncorrectable errors
// - complete flag set after program and its verify finish
// - interrupt request while complete flag and its enable are set
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module fmv_seq #(
    parameter int DF_WORDS = 512,
    parameter int AW = $clog2(DF_WORDS)
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device mode and array status
    input wire logic special_mode,
    input wire logic array_ecc_fatal,
    // read margin levels and command interrupt
    output logic [2:0] df_read_margin,
    output logic [2:0] pf_read_margin,
    output logic cmd_irq
);
    import fmv_pkg::*;

    localparam logic [16:0] DF_LIMIT = 17'(DF_WORDS);
    localparam logic [15:0] DF_BYTES = 16'(DF_WORDS * 2);

    typedef struct packed {
        fmv_state_t st;
        logic command_complete_flag;
        logic access_error_flag;
        logic protection_violation_flag;
        logic verr;
        logic uerr;
        logic command_complete_irq_enable;
        logic [2:0] idx;
        logic [2:0] launch_idx;
        logic [FMV_NUM_CCOB-1:0][15:0] ccob;
        logic [15:0] dprot;
        logic [2:0] df_margin;
        logic [2:0] pf_margin;
        logic [AW-1:0] woff;
        logic [15:0] wleft;
        logic [2:0] wnum;
        logic [31:0] rdata;
    } fmv_seq_t;

    fmv_seq_t s_q;
    fmv_seq_t s_d;

    // decodes an 18-bit global address into the data array window
    function automatic logic in_dflash(input logic [1:0] blk,
                                       input logic [15:0] a);
        in_dflash = (blk == FMV_BLK_DFLASH) && (a >= FMV_DF_START) &&
                    (a - FMV_DF_START < DF_BYTES);
    endfunction : in_dflash

    // =========================================================
    // launch-time decode of the parameter words
    logic [7:0] cmd;
    logic [1:0] blk;
    logic [15:0] gaddr;
    logic [15:0] off;
    logic [AW-1:0] woff0;
    logic [15:0] ev_cnt;
    logic [16:0] ev_end;
    logic [2:0] pg_n;
    logic [16:0] pg_end;
    logic addr_bad;
    logic mg_err;
    logic ev_err;
    logic pg_err;
    logic cmd_err;
    logic prot_hit;
    logic [AW-1:0] arr_addr;
    logic [15:0] arr_rdata;
    logic arr_wr;
    logic arr_rd;
    logic apb_wr;
    logic apb_setup;
    logic launch;

    assign cmd = s_q.ccob[FMV_IDX_CMD][15:8];
    assign blk = s_q.ccob[FMV_IDX_CMD][1:0];
    assign gaddr = s_q.ccob[FMV_IDX_ADDR];
    assign off = gaddr - FMV_DF_START;
    assign woff0 = AW'(off[15:1]);
    assign ev_cnt = s_q.ccob[FMV_IDX_COUNT];
    assign ev_end = 17'(woff0) + {1'b0, ev_cnt};
    assign pg_n = s_q.launch_idx - FMV_IDX_WORD0 + 3'h1;
    assign pg_end = 17'(woff0) + 17'(pg_n);
    assign addr_bad = !in_dflash(blk, gaddr) || gaddr[0];

    // margin: index, mode, block and level checks
    assign mg_err = (s_q.launch_idx != FMV_IDX_ADDR) || !special_mode ||
                    ((blk != FMV_BLK_DFLASH) && (blk != FMV_BLK_PFLASH)) ||
                    (gaddr > FMV_MARGIN_MAX);
    // erase-verify: index, address, alignment and overrun checks
    assign ev_err = (s_q.launch_idx != FMV_IDX_COUNT) || addr_bad ||
                    (ev_cnt == 16'h0000) || (ev_end > DF_LIMIT);
    // program: index range, address, alignment and overrun checks
    assign pg_err = (s_q.launch_idx < FMV_IDX_WORD0) ||
                    (s_q.launch_idx > FMV_IDX_WORD3) || addr_bad ||
                    (pg_end > DF_LIMIT);
    assign cmd_err = (cmd == FMV_CMD_FIELD_MARGIN) ? mg_err :
                     (cmd == FMV_CMD_ERASE_VERIFY) ? ev_err :
                     (cmd == FMV_CMD_PROGRAM) ? pg_err : 1'b1;
    // protection covers the window from the start word to the end
    assign prot_hit = s_q.dprot[FMV_DPROT_EN] &&
                      (pg_end > 17'(s_q.dprot[AW-1:0]));

    // =========================================================
    // apb handshake: zero wait states
    assign pready = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign pslverr = psel && penable && (paddr > FMV_ADDR_MARGIN ||
                     paddr[1:0] != 2'b00);
    assign launch = apb_wr && (paddr == FMV_ADDR_STAT) &&
                    pwdata[FMV_STAT_COMMAND_COMPLETE_FLAG] && s_q.command_complete_flag &&
                    !s_q.access_error_flag && !s_q.protection_violation_flag;
    assign prdata = s_q.rdata;
    assign df_read_margin = s_q.df_margin;
    assign pf_read_margin = s_q.pf_margin;
    assign cmd_irq = s_q.command_complete_flag && s_q.command_complete_irq_enable;

    // array port: one address for read and write
    assign arr_wr = (s_q.st == FMV_ST_PG_WR);
    assign arr_rd = (s_q.st == FMV_ST_EV_RD) || (s_q.st == FMV_ST_PG_RD);
    assign arr_addr = s_q.woff + AW'(s_q.wnum);

    fmv_dflash #(
        .WORDS(DF_WORDS),
        .AW(AW)
    ) u_dflash (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(arr_wr),
        .wr_addr(arr_addr),
        .wr_data(s_q.ccob[FMV_IDX_WORD0 + s_q.wnum]),
        .rd_en(arr_rd),
        .rd_addr(arr_addr),
        .rd_data(arr_rdata)
    );

    // =========================================================
    // next state: register writes, read data, sequencer
    always_comb
    begin
        s_d = s_q;
        // read data captured in the setup cycle
        if (apb_setup && !pwrite)
        begin
            s_d.rdata = '0;
            case (paddr)
                FMV_ADDR_STAT:
                begin
                    s_d.rdata[FMV_STAT_COMMAND_COMPLETE_FLAG] = s_q.command_complete_flag;
                    s_d.rdata[FMV_STAT_ACCESS_ERROR_FLAG] = s_q.access_error_flag;
                    s_d.rdata[FMV_STAT_PROTECTION_VIOLATION_FLAG] = s_q.protection_violation_flag;
                    s_d.rdata[FMV_STAT_VERR] = s_q.verr;
                    s_d.rdata[FMV_STAT_UERR] = s_q.uerr;
                end
                FMV_ADDR_CFG: s_d.rdata[FMV_CFG_COMMAND_COMPLETE_IRQ_ENABLE] = s_q.command_complete_irq_enable;
                FMV_ADDR_IDX: s_d.rdata[2:0] = s_q.idx;
                FMV_ADDR_CCOB:
                    s_d.rdata[15:0] = (s_q.idx <= FMV_IDX_WORD3) ?
                                      s_q.ccob[s_q.idx] : '0;
                FMV_ADDR_DPROT: s_d.rdata[15:0] = s_q.dprot;
                FMV_ADDR_MARGIN:
                begin
                    s_d.rdata[2:0] = s_q.df_margin;
                    s_d.rdata[FMV_MARGIN_PF_LSB +: 3] = s_q.pf_margin;
                end
                default: s_d.rdata = '0;
            endcase
        end
        // register writes; parameters frozen while a command runs
        if (apb_wr && s_q.command_complete_flag)
        begin
            case (paddr)
                FMV_ADDR_STAT:
                begin
                    if (pwdata[FMV_STAT_ACCESS_ERROR_FLAG])
                        s_d.access_error_flag = 1'b0;
                    if (pwdata[FMV_STAT_PROTECTION_VIOLATION_FLAG])
                        s_d.protection_violation_flag = 1'b0;
                end
                FMV_ADDR_CFG: s_d.command_complete_irq_enable = pwdata[FMV_CFG_COMMAND_COMPLETE_IRQ_ENABLE];
                FMV_ADDR_IDX: s_d.idx = pwdata[2:0];
                FMV_ADDR_CCOB:
                    if (s_q.idx <= FMV_IDX_WORD3)
                        s_d.ccob[s_q.idx] = pwdata[15:0];
                FMV_ADDR_DPROT: s_d.dprot = pwdata[15:0];
                default: s_d.command_complete_irq_enable = s_q.command_complete_irq_enable;
            endcase
        end
        // launch: clearing the complete flag starts the check
        if (launch)
        begin
            s_d.command_complete_flag = 1'b0;
            s_d.verr = 1'b0;
            s_d.uerr = 1'b0;
            s_d.launch_idx = s_q.idx;
            s_d.st = FMV_ST_CHECK;
        end
        case (s_q.st)
            FMV_ST_IDLE: s_d.wnum = '0;
            FMV_ST_CHECK:
            begin
                s_d.woff = woff0;
                s_d.wnum = '0;
                s_d.st = FMV_ST_IDLE;
                if (cmd_err)
                begin
                    s_d.access_error_flag = 1'b1;
                    s_d.command_complete_flag = 1'b1;
                end
                else if (cmd == FMV_CMD_FIELD_MARGIN)
                begin
                    s_d.df_margin = gaddr[2:0];
                    if (blk == FMV_BLK_PFLASH)
                        s_d.pf_margin = gaddr[2:0];
                    s_d.command_complete_flag = 1'b1;
                end
                else if (cmd == FMV_CMD_ERASE_VERIFY)
                begin
                    s_d.wleft = ev_cnt;
                    s_d.st = FMV_ST_EV_RD;
                end
                else if (prot_hit)
                begin
                    s_d.protection_violation_flag = 1'b1;
                    s_d.command_complete_flag = 1'b1;
                end
                else
                begin
                    s_d.wleft = 16'(pg_n);
                    s_d.st = FMV_ST_PG_WR;
                end
            end
            FMV_ST_EV_RD: s_d.st = FMV_ST_EV_CMP;
            FMV_ST_EV_CMP:
            begin
                if (arr_rdata != FMV_ERASED)
                    s_d.verr = 1'b1;
                if (array_ecc_fatal)
                    s_d.uerr = 1'b1;
                s_d.wleft = s_q.wleft - 16'h0001;
                s_d.woff = s_q.woff + AW'(1);
                s_d.st = (s_q.wleft == 16'h0001) ? FMV_ST_IDLE : FMV_ST_EV_RD;
                s_d.command_complete_flag = (s_q.wleft == 16'h0001);
            end
            FMV_ST_PG_WR: s_d.st = FMV_ST_PG_RD;
            FMV_ST_PG_RD: s_d.st = FMV_ST_PG_CMP;
            FMV_ST_PG_CMP:
            begin
                if (arr_rdata != s_q.ccob[FMV_IDX_WORD0 + s_q.wnum])
                    s_d.verr = 1'b1;
                if (array_ecc_fatal)
                    s_d.uerr = 1'b1;
                s_d.wnum = s_q.wnum + 3'h1;
                if (16'(s_q.wnum) + 16'h0001 == s_q.wleft)
                begin
                    s_d.command_complete_flag = 1'b1;
                    s_d.st = FMV_ST_IDLE;
                end
                else
                    s_d.st = FMV_ST_PG_WR;
            end
            default: s_d.st = FMV_ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.st <= FMV_ST_IDLE;
            s_q.command_complete_flag <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic in_chk;
    assign in_chk = (s_q.st == FMV_ST_CHECK);

    chk_margin_mode: assert property (
        in_chk && cmd == FMV_CMD_FIELD_MARGIN && !special_mode
        |=> s_q.access_error_flag && s_q.command_complete_flag && $stable(s_q.df_margin))
        else $error("margin command taken outside special mode");
    chk_fast_done: assert property (
        in_chk && cmd_err |=> s_q.command_complete_flag && s_q.st == FMV_ST_IDLE)
        else $error("failed check did not complete at once");
    chk_margin_both: assert property (
        in_chk && !cmd_err && cmd == FMV_CMD_FIELD_MARGIN &&
        blk == FMV_BLK_PFLASH
        |=> s_q.pf_margin == $past(gaddr[2:0]) &&
            s_q.df_margin == $past(gaddr[2:0]) && s_q.command_complete_flag)
        else $error("program target margin not applied to both");
    chk_margin_data: assert property (
        in_chk && !cmd_err && cmd == FMV_CMD_FIELD_MARGIN &&
        blk == FMV_BLK_DFLASH |=> $stable(s_q.pf_margin) && s_q.command_complete_flag)
        else $error("data target margin touched program reads");
    chk_margin_flags: assert property (
        in_chk && cmd == FMV_CMD_FIELD_MARGIN
        |=> !s_q.protection_violation_flag && !s_q.verr && !s_q.uerr)
        else $error("margin command set a forbidden flag");
    chk_margin_code: assert property (
        in_chk && cmd == FMV_CMD_FIELD_MARGIN && gaddr > FMV_MARGIN_MAX
        |=> s_q.access_error_flag)
        else $error("invalid margin code accepted");
    chk_ev_align: assert property (
        in_chk && cmd == FMV_CMD_ERASE_VERIFY && gaddr[0] |=> s_q.access_error_flag)
        else $error("odd erase-verify address accepted");
    chk_ev_flag: assert property (
        s_q.st == FMV_ST_EV_CMP && arr_rdata != FMV_ERASED
        |=> s_q.verr && !s_q.protection_violation_flag)
        else $error("non-erased word not flagged");
    chk_pg_count: assert property (
        in_chk && !cmd_err && !prot_hit && cmd == FMV_CMD_PROGRAM
        |=> s_q.wleft == 16'($past(s_q.launch_idx) - 3'h1))
        else $error("program word count wrong");
    chk_pg_prot: assert property (
        in_chk && !cmd_err && prot_hit && cmd == FMV_CMD_PROGRAM
        |=> s_q.protection_violation_flag && s_q.command_complete_flag ##1 !arr_wr)
        else $error("protected area not refused");
    chk_pg_index: assert property (
        in_chk && cmd == FMV_CMD_PROGRAM && s_q.launch_idx > FMV_IDX_WORD3
        |=> s_q.access_error_flag)
        else $error("program index above range accepted");
    chk_pg_finish: assert property (
        s_q.st == FMV_ST_PG_WR |=> arr_rd ##1 s_q.st == FMV_ST_PG_CMP)
        else $error("program write not followed by verify");
    chk_irq_rise: assert property (
        $rose(s_q.command_complete_flag) && s_q.command_complete_irq_enable |-> cmd_irq ##1 (cmd_irq || !s_q.command_complete_irq_enable ||
        !s_q.command_complete_flag))
        else $error("command interrupt missing");

    cov_margin: cover property (in_chk && !cmd_err &&
                                cmd == FMV_CMD_FIELD_MARGIN);
    cov_ev_done: cover property (s_q.st == FMV_ST_EV_CMP ##1 s_q.command_complete_flag);
    cov_pg_four: cover property (in_chk && !cmd_err && pg_n == 3'h4 &&
                                 cmd == FMV_CMD_PROGRAM);
    cov_access_error_flag: cover property (in_chk && cmd_err);

endmodule : fmv_seq

// ==== verif/fmv_seq_bench.sv ====
// fmv_seq_bench: self-checking bench for the margin, erase-verify and
// program command sequencer, driven over APB.
// assumes: fmv_pkg compiled first; data array shrunk to 16 words.
`timescale 1ns/1ps
module flash_margin_verify_program_cmds_bench;
    import fmv_pkg::*;

    // =========================================================
    // port signals and counters
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, slv_q;
    logic special_mode = 1'b0, array_ecc_fatal = 1'b0;
    logic [2:0] df_read_margin, pf_read_margin;
    logic cmd_irq;
    int n_mismatch = 0, compares = 0;

    // device under test, window 0x0400 .. 0x041F
    fmv_seq #(.DF_WORDS(16)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .special_mode(special_mode),
        .array_ecc_fatal(array_ecc_fatal),
        .df_read_margin(df_read_margin), .pf_read_margin(pf_read_margin),
        .cmd_irq(cmd_irq));

    // 50 MHz clock
    always #10 pclk = ~pclk;

    // =========================================================
    // bus cycles and comparison
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // access phase lasts until the slave answers, watchdog bounds it
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        slv_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // load words 0..3, launch at index ix, poll for completion
    task automatic run(input logic [15:0] w [4], input logic [2:0] ix,
                       input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        wr(FMV_ADDR_STAT, 32'h30);
        for (int k = 0; k < 4; k++)
        begin
            wr(FMV_ADDR_IDX, 32'(k));
            wr(FMV_ADDR_CCOB, {16'h0, w[k]});
        end
        wr(FMV_ADDR_IDX, {29'h0, ix});
        wr(FMV_ADDR_STAT, 32'h80);
        q = 32'h0;
        // only status reads while the command runs, watchdog bounds it
        while (q[FMV_STAT_COMMAND_COMPLETE_FLAG] !== 1'b1)
        begin
            apb(1'b0, FMV_ADDR_STAT, 32'h0, q);
        end
        chk("status", e, q & m);
    endtask : run

    task automatic chk_mg(input logic [2:0] d, input logic [2:0] p);
        chk("df_margin", {29'h0, d}, {29'h0, df_read_margin});
        chk("pf_margin", {29'h0, p}, {29'h0, pf_read_margin});
    endtask : chk_mg

    // =========================================================
    // scenarios
    task automatic t_margin;
        logic [31:0] q;
        run('{16'h0E00, 16'h3, 0, 0}, 3'h1, 32'hA0, 32'hB3);
        special_mode <= 1'b1;
        for (int lv = 0; lv < 5; lv++)
        begin
            run('{16'h0E00, 16'(lv), 0, 0}, 3'h1, 32'h80, 32'hB3);
            chk_mg(3'(lv), 3'h0);
        end
        run('{16'h0E03, 16'h2, 0, 0}, 3'h1, 32'h80, 32'hB3);
        chk_mg(3'h2, 3'h2);
        run('{16'h0E00, 16'h1, 0, 0}, 3'h1, 32'h80, 32'hB3);
        apb(1'b0, FMV_ADDR_MARGIN, 32'h0, q);
        chk("margin_reg", 32'h21, q);
        run('{16'h0E00, 16'h5, 0, 0}, 3'h1, 32'hA0, 32'hB3);
        run('{16'h0E00, 16'h1, 0, 0}, 3'h0, 32'hA0, 32'hB3);
        run('{16'h0E01, 16'h1, 0, 0}, 3'h1, 32'hA0, 32'hB3);
        chk_mg(3'h1, 3'h2);
    endtask : t_margin

    task automatic t_erase;
        run('{16'h1000, 16'h0400, 16'd16, 0}, 3'h2, 32'h80, 32'hB3);
        run('{16'h1000, 16'h0401, 16'd1, 0}, 3'h2, 32'hA0, 32'hB3);
        run('{16'h1000, 16'h041C, 16'd3, 0}, 3'h2, 32'hA0, 32'hB3);
        run('{16'h1000, 16'h0400, 16'd1, 0}, 3'h1, 32'hA0, 32'hB3);
        run('{16'h1001, 16'h0400, 16'd1, 0}, 3'h2, 32'hA0, 32'hB3);
        array_ecc_fatal <= 1'b1;
        run('{16'h1000, 16'h0400, 16'd1, 0}, 3'h2, 32'h01, 32'h11);
        array_ecc_fatal <= 1'b0;
    endtask : t_erase

    task automatic t_prog;
        run('{16'h1100, 16'h0400, 16'h1234, 16'h5678}, 3'h3, 32'h80,
            32'hB3);
        run('{16'h1000, 16'h0402, 16'd1, 0}, 3'h2, 32'h82, 32'hB3);
        run('{16'h1000, 16'h0404, 16'd1, 0}, 3'h2, 32'h80, 32'hB3);
        run('{16'h1100, 16'h0404, 16'h1, 0}, 3'h1, 32'hA0, 32'hB3);
        run('{16'h1100, 16'h0404, 16'h1, 0}, 3'h6, 32'hA0, 32'hB3);
        run('{16'h1100, 16'h041E, 16'h1, 16'h2}, 3'h3, 32'hA0,
            32'hB3);
        run('{16'h1100, 16'h0405, 16'h1, 0}, 3'h2, 32'hA0, 32'hB3);
        wr(FMV_ADDR_DPROT, 32'h8008);
        run('{16'h1100, 16'h0410, 16'hAAAA, 0}, 3'h2, 32'h90,
            32'hB3);
        run('{16'h1000, 16'h0410, 16'd1, 0}, 3'h2, 32'h80, 32'hB3);
        array_ecc_fatal <= 1'b1;
        run('{16'h1100, 16'h0408, 16'h1111, 0}, 3'h2, 32'h01,
            32'h01);
        array_ecc_fatal <= 1'b0;
    endtask : t_prog

    task automatic t_irq_map;
        logic [31:0] q;
        chk("irq", 32'h0, {31'h0, cmd_irq});
        wr(FMV_ADDR_CFG, 32'h80);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, cmd_irq});
        // unknown command code with the enable set: refused, irq on finish
        run('{16'h0000, 16'h0000, 0, 0}, 3'h0, 32'hA0, 32'hB3);
        chk("irq", 32'h1, {31'h0, cmd_irq});
        chk("pready", 32'h1, {31'h0, pready});
        wr(FMV_ADDR_CFG, 32'h0);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, cmd_irq});
        wr(8'h18, 32'hFFFF);
        chk("slverr", 32'h1, {31'h0, slv_q});
        apb(1'b0, 8'h18, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask : t_irq_map

    // =========================================================
    // verdict
    task automatic end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // watchdog, about 50000 cycles
    initial
    begin
        #1000000;
        n_mismatch++;
        end_of_test();
    end

    // reset, reset values, then the scenarios
    initial
    begin
        logic [31:0] q;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FMV_ADDR_STAT, 32'h0, q);
        chk("reset_status", 32'h80, q);
        t_irq_map();
        t_margin();
        t_erase();
        t_prog();
        end_of_test();
    end
endmodule : flash_margin_verify_program_cmds_bench
